// ### inc/adc_spi_pkg.sv
// ===========================================================================
// Purpose: Shared constants, types and check-byte function for the ADC SPI port
// Assumes: Commands are two bytes, optional trailing check byte
// Notes:   Check byte is CRC-8 over x^8+x^2+x+1 with the first byte inverted
// ===========================================================================
package adc_spi_pkg;

  // ==========================================================================
  // Command encoding
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [7:0] NOP_CHECK = 8'hd7;

  // ==========================================================================
  // Check byte
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hff;

  // ==========================================================================
  // Frame sizes and edge counts
  localparam logic [5:0] CMD_BITS = 6'h10;
  localparam logic [5:0] CMD_CHECK_BITS = 6'h18;
  localparam logic [5:0] FRAME_BITS_16 = 6'h10;
  localparam logic [5:0] FRAME_BITS_24 = 6'h18;
  localparam logic [5:0] FRAME_BITS_32 = 6'h20;
  localparam logic [5:0] MSB_EDGE_PLAIN = 6'h08;
  localparam logic [5:0] MSB_EDGE_HEADER = 6'h10;

  // ==========================================================================
  // Status header fields and reset values
  localparam int ERR_BIT = 6;
  localparam int NEW_BIT = 0;
  localparam logic CONV_READY_N_RST = 1'b1;

  // ==========================================================================
  // Conversion control modes
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_START_STOP = 2'h1;
  localparam logic [1:0] MODE_ONE_SHOT = 2'h2;

  // Frame sequencing, one-hot
  typedef enum logic [2:0] {
    FS_IDLE = 3'b001,
    FS_SHIFT = 3'b010,
    FS_CLOSE = 3'b100
  } frame_state_e;

  // Pins driven by the host
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } spi_pins_s;

  // Register write request toward the register file
  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [7:0] data;
  } reg_write_s;

  // One byte step of the check code
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

endpackage

// ### src/adc_spi_port.sv
// ===========================================================================
// Purpose: Command decode and frame output of a delta-sigma ADC serial port
// Assumes: Host pins arrive asynchronously; clock is far faster than sclk
// Notes:   Register file lives outside; writes leave as a one-cycle request
// Function
// - With checking, the two bytes before the final check byte are the command.
// - No-operation is two zero bytes, check byte D7h when checking.
// - Read command is 40h plus address; second byte arbitrary but checked.
// - Read data is sent in the frame after the read command.
// - Read of an address outside the register range returns 00h.
// - Response is register byte MSB first then one 00h pad byte.
// - Input check covers only the two command bytes, not leading pads.
// - Output check byte covers all bytes before it, header and pads included.
// - Write command is 80h plus address then the data byte, one frame.
// - Writes to addresses outside the register range are ignored.
// - Check mismatch sets error flag; writes blocked except status; writing 1 clears.
// - All-zero input frame with checking fails and sets the error flag.
// - Without command, conversion data shifts out unless previous frame was a read.
// - Conversion result is buffered and may be read repeatedly until replaced.
// - After a read command frame, register byte plus pad replaces conversion data.
// - Ready output goes high at eighth data falling edge except in one-shot mode.
// - Read stopped after MSB byte clears header new bit and raises ready output except in one-shot mode.
// - Before first sclk, dual output holds level if select 0, follows ready if 1.
// - Chip select rise decodes last 16 or 24 bits; high means idle, pin undriven.
// - Output frame is 16, 24 with header or check, 32 with both.
// - Check bytes use polynomial 100000111 with first byte inverted.
// - Outputs change on rising sclk, inputs sampled on falling sclk.
// ===========================================================================
`timescale 1ns/10ps

module adc_spi_port #(
  parameter int REG_COUNT = 15,
  parameter logic [3:0] STATUS_ADDR = 4'h2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire adc_spi_pkg::spi_pins_s spi_pins,
  input wire logic check_enable,
  input wire logic header_enable,
  input wire logic output_pin_function_select,
  input wire logic [1:0] control_mode,
  input wire logic conv_start,
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  input wire logic [7:0] status_in,
  input wire logic [7:0] reg_rdata,
  output logic [3:0] reg_rd_addr,
  output adc_spi_pkg::reg_write_s reg_write,
  output logic command_error,
  output logic conversion_ready_n,
  output logic dual_function_output,
  output logic dual_function_output_oe
);

  // ==========================================================================
  // Parameter checks
  if (REG_COUNT < 1 || REG_COUNT > 16) begin : g_bad_count
    $error("REG_COUNT must lie in 1..16");
  end

  // ==========================================================================
  // Synchronisers: stage one feeds stage two only
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic cs_prev_q;
  logic sclk_prev_q;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  // Two flops per host pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 3'h4;
      sync2_q <= 3'h4;
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {spi_pins.cs_n, spi_pins.sclk, spi_pins.sdi};
      sync2_q <= sync1_q;
      cs_prev_q <= sync2_q[2];
      sclk_prev_q <= sync2_q[1];
    end
  end

  // Edge detection on synchronised pins
  assign cs_n_s = sync2_q[2];
  assign sclk_s = sync2_q[1];
  assign sdi_s = sync2_q[0];
  assign sclk_rise = !cs_n_s && sclk_s && !sclk_prev_q;
  assign sclk_fall = !cs_n_s && !sclk_s && sclk_prev_q;
  assign cs_fall = !cs_n_s && cs_prev_q;
  assign cs_rise = cs_n_s && !cs_prev_q;

  // ==========================================================================
  // Frame sequencing
  adc_spi_pkg::frame_state_e state_q;

  // Idle while deselected, shift while selected, one close cycle after
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= adc_spi_pkg::FS_IDLE;
    end else begin
      case (state_q)
        adc_spi_pkg::FS_IDLE: if (cs_fall) state_q <= adc_spi_pkg::FS_SHIFT;
        adc_spi_pkg::FS_SHIFT: if (cs_rise) state_q <= adc_spi_pkg::FS_CLOSE;
        adc_spi_pkg::FS_CLOSE: state_q <= cs_n_s ? adc_spi_pkg::FS_IDLE : adc_spi_pkg::FS_SHIFT;
        default: state_q <= adc_spi_pkg::FS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Input shifter
  logic [23:0] in_shift_q;
  logic [5:0] fall_cnt_q;

  // Sample on falling sclk, count edges, saturating
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_shift_q <= 24'h00_0000;
      fall_cnt_q <= 6'h00;
    end else if (cs_fall) begin
      fall_cnt_q <= 6'h00;
    end else if (sclk_fall) begin
      in_shift_q <= {in_shift_q[22:0], sdi_s};
      if (fall_cnt_q != 6'h3f) begin
        fall_cnt_q <= fall_cnt_q + 6'h01;
      end
    end
  end

  // ==========================================================================
  // Command decode at frame end
  logic [15:0] cmd;
  logic enough_bits;
  logic check_bad;
  logic addr_ok;
  logic frame_end;
  logic do_write;
  logic do_read;
  logic err_clear;

  // Pick the last two command bytes and test the check byte
  always_comb begin
    if (check_enable) begin
      cmd = in_shift_q[23:8];
      enough_bits = fall_cnt_q >= adc_spi_pkg::CMD_CHECK_BITS;
    end else begin
      cmd = in_shift_q[15:0];
      enough_bits = fall_cnt_q >= adc_spi_pkg::CMD_BITS;
    end
    // Pads ahead of the command never enter the code
    check_bad = check_enable && (adc_spi_pkg::crc8_step(adc_spi_pkg::crc8_step(adc_spi_pkg::CRC_INIT,
                cmd[15:8]), cmd[7:0]) != in_shift_q[7:0]);
  end

  assign addr_ok = {1'b0, cmd[11:8]} < 5'(REG_COUNT);
  assign frame_end = cs_rise && state_q == adc_spi_pkg::FS_SHIFT && enough_bits;
  assign do_read = frame_end && !check_bad && cmd[15:14] == adc_spi_pkg::CMD_READ;
  assign do_write = frame_end && !check_bad && cmd[15:14] == adc_spi_pkg::CMD_WRITE && addr_ok
                    && (!command_error || cmd[11:8] == STATUS_ADDR);
  assign err_clear = do_write && cmd[11:8] == STATUS_ADDR && cmd[adc_spi_pkg::ERR_BIT];

  // Error flag: a new mismatch wins over a clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      command_error <= 1'b0;
    end else if (frame_end && check_bad) begin
      command_error <= 1'b1;
    end else if (err_clear) begin
      command_error <= 1'b0;
    end
  end

  // One-cycle write request toward the register file
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_write <= '0;
    end else begin
      reg_write.en <= do_write;
      if (do_write) begin
        reg_write.addr <= cmd[11:8];
        reg_write.data <= cmd[7:0];
      end
    end
  end

  // ==========================================================================
  // Read response tracking
  logic rd_pending_q;
  logic [7:0] rd_byte_q;

  // A read arms the next frame; any other closed frame disarms it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_pending_q <= 1'b0;
      reg_rd_addr <= 4'h0;
    end else if (cs_rise) begin
      rd_pending_q <= do_read;
      if (do_read) begin
        reg_rd_addr <= cmd[11:8];
      end
    end
  end

  // Register byte captured while deselected
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_byte_q <= adc_spi_pkg::PAD_BYTE;
    end else if (cs_n_s && rd_pending_q) begin
      rd_byte_q <= ({1'b0, reg_rd_addr} < 5'(REG_COUNT)) ? reg_rdata : adc_spi_pkg::PAD_BYTE;
    end
  end

  // ==========================================================================
  // Conversion buffer and ready indication
  logic [15:0] conv_buf_q;
  logic new_data_q;
  logic conv_frame_q;
  logic msb_done;

  // Result held until the next one replaces it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      conv_buf_q <= 16'h0000;
    end else if (conv_valid) begin
      conv_buf_q <= conv_data;
    end
  end

  // Last falling edge of the most significant data byte
  assign msb_done = sclk_fall && conv_frame_q && fall_cnt_q + 6'h01 ==
                    (header_enable ? adc_spi_pkg::MSB_EDGE_HEADER : adc_spi_pkg::MSB_EDGE_PLAIN);

  // Header new bit: a fresh result wins over the read attempt
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      new_data_q <= 1'b0;
    end else if (conv_valid) begin
      new_data_q <= 1'b1;
    end else if (msb_done) begin
      new_data_q <= 1'b0;
    end
  end

  // Ready output falls on a result, rises on start or, outside one-shot mode, on the data read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      conversion_ready_n <= adc_spi_pkg::CONV_READY_N_RST;
    end else if (conv_valid) begin
      conversion_ready_n <= 1'b0;
    end else if (conv_start) begin
      conversion_ready_n <= 1'b1;
    end else if (msb_done && control_mode != adc_spi_pkg::MODE_ONE_SHOT) begin
      conversion_ready_n <= 1'b1;
    end
  end

  // ==========================================================================
  // Output frame build
  logic [15:0] payload;
  logic [7:0] header;
  logic [31:0] frame;
  logic [5:0] frame_len;

  // Assemble left aligned, check byte over every byte before it
  always_comb begin
    payload = rd_pending_q ? {rd_byte_q, adc_spi_pkg::PAD_BYTE} : conv_buf_q;
    header = status_in;
    header[adc_spi_pkg::ERR_BIT] = command_error;
    header[adc_spi_pkg::NEW_BIT] = new_data_q;
    case ({header_enable, check_enable})
      2'b01: begin
        frame = {payload, adc_spi_pkg::crc8_step(adc_spi_pkg::crc8_step(adc_spi_pkg::CRC_INIT, payload[15:8]),
                 payload[7:0]), 8'h00};
        frame_len = adc_spi_pkg::FRAME_BITS_24;
      end
      2'b10: begin
        frame = {header, payload, 8'h00};
        frame_len = adc_spi_pkg::FRAME_BITS_24;
      end
      2'b11: begin
        frame = {header, payload, adc_spi_pkg::crc8_step(adc_spi_pkg::crc8_step(adc_spi_pkg::crc8_step(
                 adc_spi_pkg::CRC_INIT, header), payload[15:8]), payload[7:0])};
        frame_len = adc_spi_pkg::FRAME_BITS_32;
      end
      default: begin
        frame = {payload, 16'h0000};
        frame_len = adc_spi_pkg::FRAME_BITS_16;
      end
    endcase
  end

  // ==========================================================================
  // Output shifter and dual-function pin
  logic [31:0] out_shift_q;
  logic [5:0] out_left_q;
  logic [5:0] len_q;
  logic started_q;

  // Load at selection, shift on rising sclk
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_shift_q <= 32'h0000_0000;
      out_left_q <= 6'h00;
      len_q <= adc_spi_pkg::FRAME_BITS_16;
      conv_frame_q <= 1'b0;
      started_q <= 1'b0;
    end else if (cs_fall) begin
      out_shift_q <= frame;
      out_left_q <= frame_len;
      len_q <= frame_len;
      conv_frame_q <= !rd_pending_q;
      started_q <= 1'b0;
    end else if (sclk_rise) begin
      started_q <= 1'b1;
      if (out_left_q != 6'h00) begin
        out_shift_q <= {out_shift_q[30:0], 1'b0};
        out_left_q <= out_left_q - 6'h01;
      end
    end
  end

  // Pin level: data during the frame, ready mirror when allowed
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dual_function_output <= 1'b1;
      dual_function_output_oe <= 1'b0;
    end else begin
      dual_function_output_oe <= !cs_n_s;
      if (sclk_rise && out_left_q != 6'h00) begin
        dual_function_output <= out_shift_q[31];
      end else if (!cs_n_s && output_pin_function_select && (!started_q || fall_cnt_q >= len_q)) begin
        dual_function_output <= conversion_ready_n;
      end else if (sclk_rise) begin
        dual_function_output <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_bad_close;
    frame_end && check_bad;
  endsequence

  sequence s_read_close;
    frame_end && !check_bad && cmd[15:14] == adc_spi_pkg::CMD_READ;
  endsequence

  property p_oe_off;
    cs_n_s |=> !dual_function_output_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven while deselected");

  property p_err_set;
    s_bad_close |=> command_error ##1 (command_error || $past(err_clear));
  endproperty
  a_err_set: assert property (p_err_set) else $error("check mismatch did not set error");

  property p_wr_range;
    reg_write.en |-> {1'b0, reg_write.addr} < 5'(REG_COUNT);
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("write outside register range");

  property p_wr_blocked;
    reg_write.en && $past(command_error) |-> reg_write.addr == STATUS_ADDR;
  endproperty
  a_wr_blocked: assert property (p_wr_blocked) else $error("write passed while error set");

  property p_wr_at_end;
    reg_write.en |-> $past(cs_rise) && !$past(check_bad);
  endproperty
  a_wr_at_end: assert property (p_wr_at_end) else $error("write not at frame end");

  property p_read_arms;
    s_read_close |=> rd_pending_q;
  endproperty
  a_read_arms: assert property (p_read_arms) else $error("read did not arm response");

  property p_ready_high;
    msb_done && !conv_valid && control_mode != adc_spi_pkg::MODE_ONE_SHOT |=> conversion_ready_n && !new_data_q;
  endproperty
  a_ready_high: assert property (p_ready_high) else $error("ready not raised at eighth edge");

  property p_one_shot_low;
    control_mode == adc_spi_pkg::MODE_ONE_SHOT && !conversion_ready_n && !conv_start |=> !conversion_ready_n;
  endproperty
  a_one_shot_low: assert property (p_one_shot_low) else $error("one-shot ready rose during read");

  property p_response_load;
    cs_fall && rd_pending_q && !header_enable |=> out_shift_q[31:16] == {rd_byte_q, adc_spi_pkg::PAD_BYTE};
  endproperty
  a_response_load: assert property (p_response_load) else $error("response frame wrong");

  property p_bad_addr_zero;
    cs_n_s && rd_pending_q && {1'b0, reg_rd_addr} >= 5'(REG_COUNT) |=> rd_byte_q == adc_spi_pkg::PAD_BYTE;
  endproperty
  a_bad_addr_zero: assert property (p_bad_addr_zero) else $error("out of range read not zero");

endmodule // adc_spi_port

// ### verif/spi_host_model.sv
// Purpose: Host controller model that drives SPI frames into the port
// Assumes: sclk idles low, 80 ns period, pins change on falling clock
// Notes: sdi shows the inverted last bit between frames
`timescale 1ns/10ps

module spi_host_model (
  input wire logic clock,
  input wire logic miso,
  output adc_spi_pkg::spi_pins_s pins
);
  logic [31:0] rx;

  // ==========================================================================
  // Idle pins
  initial begin
    pins = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
  end

  task automatic go(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Select the port and wait before the first clock
  task automatic open_frame();
    go(1);
    pins.cs_n = 1'b0;
    go(6);
  endtask

  // Shift n bits MSB first; the host samples late in the low phase
  task automatic shift(input logic [31:0] tx, input int n);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      pins.sdi = tx[i];
      pins.sclk = 1'b1;
      go(4);
      pins.sclk = 1'b0;
      go(3);
      rx = {rx[30:0], miso};
      go(1);
    end
  endtask

  // End the frame, leave time for decode
  task automatic close_frame();
    pins.cs_n = 1'b1;
    pins.sdi = ~pins.sdi;
    go(10);
  endtask

  task automatic xfer(input logic [31:0] tx, input int n);
    open_frame();
    shift(tx, n);
    close_frame();
  endtask
endmodule // spi_host_model

// ### verif/adc_spi_command_frames_bench.sv
// Purpose: Self-checking bench of the ADC SPI command and frame port
// Assumes: Host model drives pins; register file modelled by assign
// Notes: Expected check bytes come from a local CRC routine
`timescale 1ns/10ps

module adc_spi_command_frames_bench;
  logic clock, arst_n, check_enable, header_enable, output_pin_function_select;
  logic conv_start, conv_valid, command_error, conversion_ready_n;
  logic dual_function_output, dual_function_output_oe;
  logic [1:0] control_mode;
  logic [15:0] conv_data, d;
  logic [7:0] status_in, reg_rdata;
  logic [3:0] reg_rd_addr;
  logic miso_line;
  adc_spi_pkg::reg_write_s reg_write, wr_last;
  adc_spi_pkg::spi_pins_s spi_pins;
  int num_errors = 0;
  int n_checks = 0;
  int wr_count = 0;

  // ==========================================================================
  // Design, host and register data
  adc_spi_port uut (
    .clock, .arst_n, .spi_pins, .check_enable, .header_enable,
    .output_pin_function_select, .control_mode, .conv_start, .conv_valid,
    .conv_data, .status_in, .reg_rdata, .reg_rd_addr, .reg_write,
    .command_error, .conversion_ready_n, .dual_function_output,
    .dual_function_output_oe
  );
  spi_host_model host (.clock, .miso(miso_line), .pins(spi_pins));
  // Released line shows the inverse so stale data cannot pass a compare
  assign miso_line = dual_function_output_oe ? dual_function_output : ~dual_function_output;
  assign reg_rdata = {4'h9, reg_rd_addr}; // Out of range still answers data

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] crc(input logic [31:0] v, input int nb);
    logic [7:0] c;
    c = 8'hff;
    for (int k = nb - 1; k >= 0; k--) begin
      c = c ^ v[8*k+:8];
      for (int j = 0; j < 8; j++) begin
        c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Command bytes with their check byte
  function automatic logic [31:0] wf(input logic [7:0] a, input logic [7:0] b);
    return {8'h00, a, b, crc({16'h0000, a, b}, 2)};
  endfunction

  task automatic conv(input logic [15:0] v);
    conv_start = 1'b1;
    host.go(1);
    conv_start = 1'b0;
    conv_data = v;
    conv_valid = 1'b1;
    d = v;
    host.go(1);
    conv_valid = 1'b0;
    host.go(2);
  endtask

  task automatic done(input int t);
    $display("test %0d done", t);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Write request monitor, looks mid-cycle while the pulse stands
  always @(negedge clock) begin
    if (reg_write.en === 1'b1) begin
      wr_count++;
      wr_last = reg_write;
      chk(spi_pins.cs_n, 1'b1);
    end
  end

  // Watchdog
  initial begin
    #500us;
    num_errors++;
    end_of_test();
  end

  // Tests
  initial begin
    {arst_n, check_enable, header_enable, output_pin_function_select} = 4'h0;
    {conv_start, conv_valid, control_mode, conv_data, d} = '0;
    status_in = 8'h24;
    repeat (6) @(negedge clock);
    arst_n = 1'b1;
    chk({dual_function_output_oe, conversion_ready_n, command_error}, 3'h2);
    chk({reg_write.en, reg_rd_addr}, 5'h00);
    done(1);
    for (int m = 0; m < 3; m++) begin
      control_mode = 2'(m);
      conv(16'ha53c + 16'(m));
      chk(conversion_ready_n, 1'b0);
      host.xfer(32'h0000_0000, 16);
      chk(host.rx, d);
      chk(conversion_ready_n, m != 2);
      chk(dual_function_output_oe, 1'b0);
    end
    host.xfer(32'h0000_0000, 16);
    chk(host.rx, d);
    done(2);
    host.xfer(32'h0000_835a, 16);
    chk({wr_count, wr_last}, {32'h1, 13'h1_35a});
    host.xfer(32'h0000_8f11, 16);
    chk(wr_count, 1);
    done(3);
    host.xfer(32'h0000_45ff, 16);
    chk(reg_rd_addr, 4'h5);
    host.xfer(32'h0000_4f00, 16);
    chk(host.rx, 16'h9500);
    host.xfer(32'h0000_0000, 8);
    chk(host.rx, 8'h00);
    host.xfer(32'h0000_0000, 16);
    chk(host.rx, d);
    done(4);
    check_enable = 1'b1;
    host.xfer(32'h0000_00d7, 24);
    chk(host.rx, {d, crc({16'h0000, d}, 2)});
    chk(command_error, 1'b0);
    host.xfer(32'h0000_0000, 24);
    chk(command_error, 1'b1);
    host.xfer(wf(8'h84, 8'h33), 24);
    chk(wr_count, 1);
    host.xfer(wf(8'h82, 8'h40), 24);
    chk({wr_count, command_error}, {32'h2, 1'b0});
    host.xfer(wf(8'h86, 8'h77) | 32'hc300_0000, 32);
    chk(wr_last, 13'h1_677);
    host.xfer(32'h0087_0100, 24);
    chk({wr_count, command_error}, {32'h3, 1'b1});
    host.xfer(wf(8'h82, 8'h40), 24);
    chk(command_error, 1'b0);
    done(5);
    header_enable = 1'b1;
    control_mode = 2'h0;
    conv(16'h1e2f);
    host.xfer(32'h0000_00d7, 16);
    chk(host.rx, {8'h25, d[15:8]});
    chk(conversion_ready_n, 1'b1);
    host.xfer(32'h0000_00d7, 32);
    chk(host.rx, {8'h24, d, crc({8'h00, 8'h24, d}, 3)});
    done(6);
    output_pin_function_select = 1'b1;
    conv(16'h7788);
    host.open_frame();
    chk({dual_function_output_oe, dual_function_output}, 2'h2);
    host.shift(32'h0000_00d7, 32);
    host.close_frame();
    chk(host.rx, {8'h25, d, crc({8'h00, 8'h25, d}, 3)});
    done(7);
    end_of_test();
  end
endmodule // adc_spi_command_frames_bench
